// [common/rx_config_pkg.sv]
// Purpose: constants for the receiver configuration register bank
// Assumes: word-indexed register slots, byte address is four times the index
// Notes:   field positions and reset values shared by design and bench
package rx_config_pkg;

    // ----------------------------------------
    // register slots
    // ----------------------------------------
    localparam logic [7:0] IDX_SOURCE_GUARD = 8'h17;
    localparam logic [7:0] IDX_THRESHOLDS   = 8'h18;
    localparam logic [7:0] IDX_DEMOD        = 8'h19;
    localparam logic [7:0] IDX_RSVD_A       = 8'h1a;
    localparam logic [7:0] IDX_RSVD_B       = 8'h1b;
    localparam int         ADDR_LSB         = 2;
    localparam int         ADDR_WIDTH       = 10;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_SOURCE_GUARD = 8'h84;
    localparam logic [7:0] RST_THRESHOLDS   = 8'h84;
    localparam logic [7:0] RST_DEMOD        = 8'h4d;
    localparam logic [7:0] RST_RSVD         = 8'h00;

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int SRC_SEL_LSB   = 6;
    localparam int GUARD_LSB     = 0;
    localparam int GUARD_WIDTH   = 6;
    localparam int MIN_LEVEL_LSB = 4;
    localparam int COLL_LSB      = 0;
    localparam int CHAN_MODE_LSB = 6;
    localparam int FIXED_CH_BIT  = 5;
    localparam int EVEN_PRE_BIT  = 4;
    localparam int TAU_RCV_LSB   = 2;
    localparam int TAU_BURST_LSB = 0;
    // writable bits; the threshold register has bit 3 reserved
    localparam logic [7:0] MASK_THRESHOLDS = 8'hf7;

    // ----------------------------------------
    // encodings
    // ----------------------------------------
    localparam logic [1:0] SRC_LOW        = 2'h0;
    localparam logic [1:0] SRC_MANCHESTER = 2'h1;
    localparam logic [1:0] SRC_ANALOG     = 2'h2;
    localparam logic [1:0] SRC_NRZ        = 2'h3;
    localparam logic [1:0] CHAN_STRONGER  = 2'h0;
    localparam logic [1:0] CHAN_FROZEN    = 2'h1;

    typedef enum logic [1:0] {
        GUARD_IDLE,
        GUARD_WAIT,
        GUARD_OPEN
    } guard_state_t;

endpackage : rx_config_pkg

// [verilog/receiver_config_registers.sv]
// Purpose: receiver configuration registers with source, guard and channel logic
// Assumes: one clock sys_clk at 40 MHz; bit clock and carrier ticks are enables
// Notes:   APB slave, no wait states on any access; pready is high in the first access cycle
`timescale 1ns/1ps
module receiver_config_registers
    import rx_config_pkg::*;
#(
    parameter int PRESCALER_WIDTH = 12,
    parameter bit LATER_VERSION   = 1'b1
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_WIDTH-1:0]      paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    // receive path
    input  wire logic                       externalModulationInput,
    input  wire logic                       analogDemodSignal,
    input  wire logic                       bitClockTick,
    input  wire logic                       transmitDone,
    input  wire logic                       plainReceiveStart,
    input  wire logic                       rfFieldOn,
    output logic                            receiverEnable,
    output logic                            receiveData,
    // channel choice
    input  wire logic                       qStronger,
    output logic                            useQChannel,
    // timer prescaler
    input  wire logic                       carrierTick,
    input  wire logic [PRESCALER_WIDTH-1:0] timerPrescalerValue,
    output logic                            timerTick,
    // static analog settings
    output logic [3:0]                      minimumSignalLevel,
    output logic [2:0]                      collisionThreshold,
    output logic [1:0]                      receptionPllTimeConstant,
    output logic [1:0]                      burstPllTimeConstant
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (PRESCALER_WIDTH < 1 || PRESCALER_WIDTH > 24) begin : gen_bad_width
        $error("PRESCALER_WIDTH must be 1 to 24");
    end

    localparam int DIV_WIDTH = PRESCALER_WIDTH + 2;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]           sourceGuard;
        logic [7:0]           thresholds;
        logic [7:0]           demod;
        logic                 ready;
        logic [31:0]          rdata;
        logic                 slvErr;
        logic                 extMod1;
        logic                 extMod2;
        logic                 analog1;
        logic                 analog2;
        logic                 field1;
        logic                 field2;
        logic                 fieldSeen;
        guard_state_t         guard;
        logic [5:0]           guardCount;
        logic                 rxData;
        logic                 frozenQ;
        logic                 useQ;
        logic                 rxOpen;
        logic [DIV_WIDTH-1:0] preCount;
        logic                 tick;
    } state_t;

    localparam state_t RESET_STATE = '{
        sourceGuard: RST_SOURCE_GUARD,
        thresholds:  RST_THRESHOLDS,
        demod:       RST_DEMOD,
        guard:       GUARD_IDLE,
        default:     '0
    };

    state_t state;
    state_t next_state;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    logic [7:0] wordIndex;
    logic       mapped;
    logic [7:0] readByte;
    logic       setupPhase;
    logic       writeHit;

    assign wordIndex  = 8'(paddr[ADDR_WIDTH-1:ADDR_LSB]);
    assign setupPhase = psel && !penable;
    assign writeHit   = psel && penable && state.ready && pwrite && !state.slvErr;

    always_comb begin
        mapped   = 1'b1;
        readByte = 8'h00;
        case (wordIndex)
            IDX_SOURCE_GUARD: readByte = state.sourceGuard;
            IDX_THRESHOLDS:   readByte = state.thresholds & MASK_THRESHOLDS;
            IDX_DEMOD:        readByte = state.demod;
            IDX_RSVD_A:       readByte = RST_RSVD;
            IDX_RSVD_B:       readByte = RST_RSVD;
            default:          mapped   = 1'b0;
        endcase
    end

    // ----------------------------------------
    // field views
    // ----------------------------------------
    logic [1:0] sourceSelect;
    logic [5:0] guardDelay;
    logic [1:0] channelMode;
    logic       fixedChannel;
    logic       evenPrescaler;

    assign sourceSelect  = state.sourceGuard[SRC_SEL_LSB +: 2];
    assign guardDelay    = state.sourceGuard[GUARD_LSB +: GUARD_WIDTH];
    assign channelMode   = state.demod[CHAN_MODE_LSB +: 2];
    assign fixedChannel  = state.demod[FIXED_CH_BIT];
    assign evenPrescaler = state.demod[EVEN_PRE_BIT];

    // ----------------------------------------
    // prescaler divisor
    // ----------------------------------------
    // only the later version honours the even option
    logic [DIV_WIDTH-1:0] divisor;
    logic                 evenActive;

    assign evenActive = LATER_VERSION && evenPrescaler;
    always_comb begin
        divisor = {1'b0, timerPrescalerValue, 1'b1};
        if (evenActive) begin
            divisor = DIV_WIDTH'({1'b0, timerPrescalerValue, 1'b0} + 2);
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic fieldRise;
    logic sourceBit;

    assign fieldRise = state.field2 && !state.fieldSeen;

    always_comb begin
        next_state = state;

        // synchronisers for pin-side inputs
        next_state.extMod1   = externalModulationInput;
        next_state.extMod2   = state.extMod1;
        next_state.analog1   = analogDemodSignal;
        next_state.analog2   = state.analog1;
        next_state.field1    = rfFieldOn;
        next_state.field2    = state.field1;
        next_state.fieldSeen = state.field2;

        // apb: answer in the cycle after setup
        next_state.ready  = setupPhase;
        next_state.slvErr = setupPhase && !mapped;
        if (setupPhase) begin
            next_state.rdata = (mapped && !pwrite) ? {24'h0, readByte} : 32'h0;
        end
        if (writeHit) begin
            case (wordIndex)
                IDX_SOURCE_GUARD: next_state.sourceGuard = pwdata[7:0];
                IDX_THRESHOLDS:   next_state.thresholds  = pwdata[7:0] & MASK_THRESHOLDS;
                IDX_DEMOD:        next_state.demod       = pwdata[7:0];
                default:          next_state.rdata       = state.rdata;
            endcase
        end

        // receive source mux
        case (sourceSelect)
            SRC_LOW:        sourceBit = 1'b0;
            SRC_MANCHESTER: sourceBit = state.extMod2;
            SRC_ANALOG:     sourceBit = state.analog2;
            SRC_NRZ:        sourceBit = state.extMod2;
            default:        sourceBit = 1'b0;
        endcase

        // guard time: counts bit clocks, input ignored meanwhile
        case (state.guard)
            GUARD_IDLE: begin
                next_state.guardCount = guardDelay;
            end
            GUARD_WAIT: begin
                if (state.guardCount == 6'h00) begin
                    next_state.guard = GUARD_OPEN;
                end else if (bitClockTick) begin
                    next_state.guardCount = state.guardCount - 6'h01;
                end
            end
            GUARD_OPEN: begin
                next_state.guardCount = state.guardCount;
            end
            default: begin
                next_state.guard = GUARD_IDLE;
            end
        endcase
        if (transmitDone || fieldRise) begin
            next_state.guard      = GUARD_WAIT;
            next_state.guardCount = guardDelay;
        end
        if (plainReceiveStart) begin
            next_state.guard = GUARD_OPEN;
        end
        next_state.rxData = (state.guard == GUARD_OPEN) ? sourceBit : 1'b0;
        // enable output kept as its own flop, same timing as the guard state
        next_state.rxOpen = (next_state.guard == GUARD_OPEN);

        // i/q channel choice; frozen choice taken when reception opens
        if (state.guard != GUARD_OPEN) begin
            next_state.frozenQ = qStronger;
        end
        if (fixedChannel) begin
            next_state.useQ = channelMode[0];
        end else if (channelMode == CHAN_FROZEN) begin
            next_state.useQ = state.frozenQ;
        end else begin
            // reserved modes fall back to stronger channel
            next_state.useQ = qStronger;
        end

        // timer prescaler on carrier ticks
        next_state.tick = 1'b0;
        if (carrierTick) begin
            if (state.preCount >= divisor - DIV_WIDTH'(1)) begin
                next_state.preCount = '0;
                next_state.tick     = 1'b1;
            end else begin
                next_state.preCount = state.preCount + DIV_WIDTH'(1);
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign pready                   = state.ready;
    assign prdata                   = state.rdata;
    assign pslverr                  = state.slvErr;
    assign receiverEnable           = state.rxOpen;
    assign receiveData              = state.rxData;
    assign useQChannel              = state.useQ;
    assign timerTick                = state.tick;
    assign minimumSignalLevel       = state.thresholds[MIN_LEVEL_LSB +: 4];
    assign collisionThreshold       = state.thresholds[COLL_LSB +: 3];
    assign receptionPllTimeConstant = state.demod[TAU_RCV_LSB +: 2];
    assign burstPllTimeConstant     = state.demod[TAU_BURST_LSB +: 2];

endmodule : receiver_config_registers

// [verif/receiver_config_registers_sva.sv]
// Purpose: port checks for the receiver configuration bank
// Assumes: one clock, synchronous active-low reset
// Notes:   field outputs may lag the register by one cycle
`timescale 1ns/1ps
module receiver_config_registers_sva
    import rx_config_pkg::*;
(
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  reset_n,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  pready,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    // receive and fields
    input wire logic                  plainReceiveStart,
    input wire logic                  receiverEnable,
    input wire logic                  receiveData,
    input wire logic [3:0]            minimumSignalLevel,
    input wire logic [2:0]            collisionThreshold,
    input wire logic [1:0]            receptionPllTimeConstant,
    input wire logic [1:0]            burstPllTimeConstant
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr(logic [7:0] idx);
        psel && penable && pready && pwrite && paddr[ADDR_WIDTH-1:ADDR_LSB] == idx;
    endsequence
    property p_ready; s_setup |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
    property p_thr;
        s_wr(IDX_THRESHOLDS) |=> ##1 minimumSignalLevel == $past(pwdata[7:4], 2)
            && collisionThreshold == $past(pwdata[2:0], 2);
    endproperty
    property p_pll;
        s_wr(IDX_DEMOD) |=> ##1 receptionPllTimeConstant == $past(pwdata[3:2], 2)
            && burstPllTimeConstant == $past(pwdata[1:0], 2);
    endproperty
    property p_plain; plainReceiveStart |-> ##[1:2] receiverEnable; endproperty
    property p_closed; !$past(receiverEnable) |-> !receiveData; endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    a_err: assert property (p_err) else $error("error answer carries data");
    a_upper: assert property (p_upper) else $error("upper read lanes not zero");
    a_thr: assert property (p_thr) else $error("threshold fields not updated");
    a_pll: assert property (p_pll) else $error("pll fields not updated");
    a_plain: assert property (p_plain) else $error("plain receive did not open");
    a_closed: assert property (p_closed) else $error("data while receiver closed");
endmodule : receiver_config_registers_sva
bind receiver_config_registers receiver_config_registers_sva u_sva (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .plainReceiveStart(plainReceiveStart), .receiverEnable(receiverEnable),
    .receiveData(receiveData), .minimumSignalLevel(minimumSignalLevel),
    .collisionThreshold(collisionThreshold), .receptionPllTimeConstant(receptionPllTimeConstant),
    .burstPllTimeConstant(burstPllTimeConstant));

// [verif/receiver_config_registers_tb_top.sv]
// Purpose: self-checking bench for the receiver configuration bank
// Assumes: apb answer waited for, lfsr seed fixed
// Notes:   guard waits checked loosely, a few cycles of slack around opening
`timescale 1ns/1ps
module receiver_config_registers_tb_top
    import rx_config_pkg::*;
;
    logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [ADDR_WIDTH-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic extIn = 0, anaIn = 0, bitTick = 0, txDone = 0, plainRx = 0, rfOn = 0, qStrong = 0;
    logic carTick = 1, rxEn, rxData, useQ, tmrTick, err;
    logic [11:0] preVal = '0;
    logic [3:0] minL;
    logic [2:0] coll;
    logic [1:0] tauR, tauB;
    logic [7:0] idx, wd;
    logic [15:0] seed = 16'h398f;
    logic [7:0] rv [5] = '{RST_SOURCE_GUARD, RST_THRESHOLDS, RST_DEMOD, RST_RSVD, RST_RSVD};
    int num_errors = 0, num_checks = 0, g, n;
    always #12.5 sys_clk = ~sys_clk;
    receiver_config_registers dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .externalModulationInput(extIn),
        .analogDemodSignal(anaIn), .bitClockTick(bitTick), .transmitDone(txDone),
        .plainReceiveStart(plainRx), .rfFieldOn(rfOn), .receiverEnable(rxEn),
        .receiveData(rxData), .qStronger(qStrong), .useQChannel(useQ), .carrierTick(carTick),
        .timerPrescalerValue(preVal), .timerTick(tmrTick), .minimumSignalLevel(minL),
        .collisionThreshold(coll), .receptionPllTimeConstant(tauR),
        .burstPllTimeConstant(tauB));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] mask_of(input logic [7:0] i);
        return i == IDX_THRESHOLDS ? MASK_THRESHOLDS : (i > IDX_DEMOD ? 8'h00 : 8'hff);
    endfunction : mask_of
    function automatic logic src_exp(input logic [1:0] sel, input logic e, input logic a);
        return sel == SRC_LOW ? 1'b0 : (sel == SRC_ANALOG ? a : e);
    endfunction : src_exp
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1;
        k = 0;
        // look between edges, so the answer is seen before the edge that ends the access
        @(negedge sys_clk);
        while (pready !== 1'b1 && k < 50) begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 50) num_errors++;
        rd = prdata;
        err = pslverr;
        @(posedge sys_clk);
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge sys_clk);
            bitTick <= 1;
            @(posedge sys_clk);
            bitTick <= 0;
        end
    endtask : ticks
    task automatic pulse(input bit plain);
        @(posedge sys_clk);
        if (plain) plainRx <= 1;
        else txDone <= 1;
        @(posedge sys_clk);
        plainRx <= 0;
        txDone <= 0;
    endtask : pulse
    task automatic meas(output int k);
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (tmrTick !== 1'b1 && k < 200);
        if (k >= 200) num_errors++;
    endtask : meas
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        cyc(8);
        reset_n <= 1;
        check("fields", {minL, coll, tauR, tauB}, {4'h8, 3'h4, 2'h3, 2'h1});
        for (int i = 0; i < 5; i++) begin
            apb(0, IDX_SOURCE_GUARD + 8'(i), 8'h00);
            check("reset", rd, {24'h0, rv[i]});
        end
        apb(1, 8'h30, 8'hff);
        check("unmapped", err, 1);
        for (int k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            idx = IDX_SOURCE_GUARD + 8'(seed % 5);
            wd = seed[15:8];
            apb(1, idx, wd);
            apb(0, idx, 8'h00);
            check("readback", rd, {24'h0, wd & mask_of(idx)});
            cyc(2);
            if (idx == IDX_THRESHOLDS) check("thr", {minL, 1'b0, coll}, wd & 8'hf7);
            if (idx == IDX_DEMOD) check("pll", {tauR, tauB}, wd[3:0]);
        end
        // second reset in mid-run
        reset_n <= 0;
        cyc(2);
        reset_n <= 1;
        check("rereset", {minL, coll, tauR, tauB}, {4'h8, 3'h4, 2'h3, 2'h1});
        check("rereset enable", rxEn, 0);
        apb(0, IDX_SOURCE_GUARD, 8'h00);
        check("rereset source", rd, {24'h0, RST_SOURCE_GUARD});
        g = 1 + seed % 63;
        apb(1, IDX_SOURCE_GUARD, {SRC_ANALOG, 6'(g)});
        anaIn <= 1;
        pulse(0);
        cyc(30);
        check("closed", {rxEn, rxData}, 0);
        ticks(g - 1);
        cyc(4);
        check("early", rxEn, 0);
        ticks(1);
        cyc(4);
        check("open", {rxEn, rxData}, 3);
        rfOn <= 1;
        cyc(6);
        check("field", rxEn, 0);
        ticks(g);
        cyc(4);
        check("field open", rxEn, 1);
        pulse(0);
        cyc(3);
        pulse(1);
        cyc(3);
        check("plain", rxEn, 1);
        for (int i = 0; i < 16; i++) begin
            apb(1, IDX_SOURCE_GUARD, {2'(i >> 2), 6'(g)});
            extIn <= i[0];
            anaIn <= i[1];
            cyc(6);
            check("source", rxData, src_exp(2'(i >> 2), i[0], i[1]));
        end
        for (int b = 0; b < 2; b++) begin
            apb(1, IDX_DEMOD, {1'b0, 1'(b), 1'b1, 5'h0});
            qStrong <= ~1'(b);
            cyc(3);
            check("fixed", useQ, b);
        end
        apb(1, IDX_DEMOD, 8'h00);
        for (int q = 0; q < 2; q++) begin
            qStrong <= 1'(q);
            cyc(3);
            check("stronger", useQ, q);
        end
        apb(1, IDX_DEMOD, {CHAN_FROZEN, 6'h0});
        pulse(0);
        qStrong <= 1;
        cyc(4);
        pulse(1);
        cyc(3);
        qStrong <= 0;
        cyc(4);
        check("frozen", useQ, 1);
        for (int e = 0; e < 2; e++) begin
            apb(1, IDX_DEMOD, {3'h0, 1'(e), 4'h0});
            for (int k = 0; k < 3; k++) begin
                seed = lfsr(seed);
                preVal <= 12'(1 + seed % 7);
                meas(n);
                meas(n);
                meas(n);
                check("divisor", n, 2 * (1 + seed % 7) + 1 + e);
            end
        end
        finish_test();
    end
    initial begin
        cyc(20000);
        num_errors++;
        finish_test();
    end
endmodule : receiver_config_registers_tb_top
